// ===== wdog_pkg.sv
// package for the watchdog block: register map, field positions, reset values, timing
// assumes an AXI4-Lite master with 32-bit data; registers are one aligned word each
// How it works
// - sixteen-bit up counter advancing on prescaled ticks
// - machine cycle is clk/12, then /2 or /128
// - counter bytes read only, writes ignored
// - watchdog start accepted only in watchdog mode
// - one cycle after start load reload, clear low
// - reload writable anytime, loaded only on events
// - running watchdog cannot stop, mode write ignored
// - refresh bit then start on very next write
// - refresh bit self-clears after three machine cycles
// - refresh clears low byte, loads high byte
// - watchdog overflow raises internal watchdog reset
// - normal reset clears all bits and counter
// - watchdog reset keeps start, keep bit, flags source
// - without keep bit reload and prescaler cleared
// - power-down stops, idle freezes watchdog mode only
// - peripheral save freezes timer mode only
// - timeout follows prescale and reload formula
// - timer mode selectable only before watchdog start
// - timer start clears flag, loads, counts up
// - timer overflow sets flag and irq source only
// - timer reloads after overflow, stops when cleared
// - mode locked while running unless cleared together
package wdog_pkg;
    localparam logic [7:0] ADDR_RELOAD = 8'h00;
    localparam logic [7:0] ADDR_REFRESH = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_CNT_LOW = 8'h0C;
    localparam logic [7:0] ADDR_CNT_HIGH = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // control register bits
    localparam int CTRL_START = 0;
    localparam int CTRL_PRESCALE = 1;
    localparam int CTRL_TMR_MODE = 2;
    localparam int CTRL_GP_RUN = 3;
    localparam int CTRL_KEEP = 4;
    localparam int CTRL_WD_RST = 5;
    // refresh register bit
    localparam int REFRESH_BIT = 0;
    // status register bits
    localparam int STAT_OVF = 0;
    localparam int STAT_IRQ_SRC = 1;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [3:0] MACHINE_DIV = 4'hB;
    localparam logic [6:0] PRE_DIV_FAST = 7'h01;
    localparam logic [6:0] PRE_DIV_SLOW = 7'h7F;
    localparam logic [1:0] REFRESH_LIFE = 2'h3;
    localparam logic [3:0] WD_RST_LEN = 4'hF;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic idle_mode;
        logic power_down;
        logic peripheral_save_bit_save;
    } power_t;

    typedef enum logic [1:0] {
        WD_IDLE = 2'b00,
        WD_RUN = 2'b01,
        WD_RESET = 2'b10
    } wd_state_t;
endpackage

// ===== wdog.sv
// watchdog with general purpose timer mode, AXI4-Lite register slave
// assumes power mode levels synchronous to clk; wd_reset_out feeds the system reset logic
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module wdog
    import wdog_pkg::*;
(
    input wire logic clk, // 100 MHz system clock
    input wire logic rst_n, // async normal reset
    input wire power_t pwr, // power mode levels
    output logic wd_reset_out, // internal watchdog reset request
    output logic gp_timer_irq_source, // interrupt source bit to central register
    input wire logic irq_src_clear, // software clears the source bit
    input wire logic gp_timer_irq_enable, // enable bit from irq enable register
    output logic gp_timer_irq, // timer interrupt
    input wire logic [7:0] s_awaddr, // write address
    input wire logic s_awvalid, // write address valid
    output logic s_awready, // write address ready
    input wire logic [31:0] s_wdata, // write data
    input wire logic [3:0] s_wstrb, // write strobes
    input wire logic s_wvalid, // write data valid
    output logic s_wready, // write data ready
    output logic [1:0] s_bresp, // write response
    output logic s_bvalid, // write response valid
    input wire logic s_bready, // write response ready
    input wire logic [7:0] s_araddr, // read address
    input wire logic s_arvalid, // read address valid
    output logic s_arready, // read address ready
    output logic [31:0] s_rdata, // read data
    output logic [1:0] s_rresp, // read response
    output logic s_rvalid, // read valid
    input wire logic s_rready // read ready
);
    logic [7:0] reload_r;
    logic [15:0] cnt_r;
    logic start_r, prescale_r, tmr_mode_r, gp_run_r, keep_r, wd_rst_flag_r;
    logic refresh_r, refresh_armed_r;
    logic [1:0] refresh_age_r;
    logic ovf_flag_r, irq_src_r;
    logic [3:0] mdiv_r;
    logic [6:0] pdiv_r;
    logic [3:0] rst_len_r;
    logic load_pend_r;
    logic aw_got_r, w_got_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    logic bvalid_r, rvalid_r;

    // bus write path: address and data taken in either order
    wire aw_take = s_awvalid && s_awready;
    wire w_take = s_wvalid && s_wready;
    wire aw_have = aw_got_r || aw_take;
    wire w_have = w_got_r || w_take;
    wire wr_fire = aw_have && w_have && !bvalid_r;
    wire [7:0] wr_addr = aw_got_r ? aw_addr_r : s_awaddr;
    wire [31:0] wr_data = w_got_r ? w_data_r : s_wdata;
    wire [3:0] wr_strb = w_got_r ? w_strb_r : s_wstrb;
    wire wr_lane0 = wr_fire && wr_strb[0];
    wire wr_reload = wr_lane0 && (wr_addr == ADDR_RELOAD);
    wire wr_refresh = wr_lane0 && (wr_addr == ADDR_REFRESH);
    wire wr_ctrl = wr_lane0 && (wr_addr == ADDR_CTRL);
    wire wr_status = wr_lane0 && (wr_addr == ADDR_STATUS);
    wire wr_known = (wr_addr == ADDR_RELOAD) || (wr_addr == ADDR_REFRESH)
        || (wr_addr == ADDR_CTRL) || (wr_addr == ADDR_STATUS)
        || (wr_addr == ADDR_CNT_LOW) || (wr_addr == ADDR_CNT_HIGH);
    assign s_awready = !aw_got_r && !bvalid_r;
    assign s_wready = !w_got_r && !bvalid_r;
    assign s_bvalid = bvalid_r;
    assign s_bresp = bresp_r;

    // prescaler: machine cycle every 12 clk, then /2 or /128
    wire halted = pwr.power_down;
    wire mtick = (mdiv_r == MACHINE_DIV) && !halted;
    wire [6:0] pdiv_max = prescale_r ? PRE_DIV_SLOW : PRE_DIV_FAST;
    wire ptick = mtick && (pdiv_r >= pdiv_max);
    // freeze conditions per mode
    wire wd_running = start_r && !tmr_mode_r;
    wire gp_running = gp_run_r && tmr_mode_r;
    wire wd_count_en = wd_running && !pwr.idle_mode && !wd_reset_out;
    wire gp_count_en = gp_running && !pwr.peripheral_save_bit_save;
    wire cnt_tick = ptick && (wd_count_en || gp_count_en);
    wire wrap = cnt_tick && (cnt_r == 16'hFFFF);

    // control write decode
    wire new_start = wr_data[CTRL_START];
    wire new_mode = wr_data[CTRL_TMR_MODE];
    wire new_gp = wr_data[CTRL_GP_RUN];
    // mode change only when nothing runs, or gp stop written together
    wire mode_ok = !start_r && (!gp_run_r || !new_gp);
    wire mode_nxt = mode_ok ? new_mode : tmr_mode_r;
    wire wd_start_req = wr_ctrl && new_start && !mode_nxt;
    // refresh valid only if armed by the immediately preceding write
    wire refresh_hit = wd_start_req && start_r && refresh_armed_r;
    wire wd_start_new = wd_start_req && !start_r;
    wire gp_start_new = wr_ctrl && new_gp && mode_nxt && !gp_run_r;
    wire wd_ovf = wrap && wd_running;
    wire gp_ovf = wrap && gp_running;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mdiv_r <= 4'h0;
            pdiv_r <= 7'h00;
        end else begin
            mdiv_r <= (mdiv_r == MACHINE_DIV || halted) ? 4'h0 : mdiv_r + 4'h1;
            if (!(wd_running || gp_running) || ptick || load_pend_r)
                pdiv_r <= 7'h00;
            else if (mtick)
                pdiv_r <= pdiv_r + 7'h01;
        end
    end

    // control register and refresh arm
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            start_r <= 1'b0;
            prescale_r <= 1'b0;
            tmr_mode_r <= 1'b0;
            gp_run_r <= 1'b0;
            keep_r <= 1'b0;
            wd_rst_flag_r <= 1'b0;
        end else if (wd_ovf) begin
            wd_rst_flag_r <= 1'b1;
            gp_run_r <= 1'b0;
            if (!keep_r)
                prescale_r <= 1'b0;
        end else if (wr_ctrl && !wd_reset_out) begin
            if (new_start && !mode_nxt)
                start_r <= 1'b1;
            prescale_r <= wr_data[CTRL_PRESCALE];
            tmr_mode_r <= mode_nxt;
            gp_run_r <= new_gp && mode_nxt;
            keep_r <= wr_data[CTRL_KEEP];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            refresh_r <= 1'b0;
            refresh_armed_r <= 1'b0;
            refresh_age_r <= 2'h0;
        end else begin
            if (wr_refresh && wr_data[REFRESH_BIT]) begin
                refresh_r <= 1'b1;
                refresh_age_r <= 2'h0;
            end else if (refresh_r && mtick) begin
                refresh_age_r <= refresh_age_r + 2'h1;
                if (refresh_age_r == REFRESH_LIFE - 2'h1)
                    refresh_r <= 1'b0;
            end
            // any other write in between disarms the refresh
            if (wr_fire)
                refresh_armed_r <= wr_refresh && wr_data[REFRESH_BIT];
        end
    end

    // reload register: writable anytime
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            reload_r <= RELOAD_RST;
        else if (wd_ovf && !keep_r)
            reload_r <= RELOAD_RST;
        else if (wr_reload)
            reload_r <= wr_data[7:0];
    end

    // watchdog reset pulse, stretched for a fixed length
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            rst_len_r <= 4'h0;
        else if (wd_ovf)
            rst_len_r <= WD_RST_LEN;
        else if (rst_len_r != 4'h0)
            rst_len_r <= rst_len_r - 4'h1;
    end
    assign wd_reset_out = (rst_len_r != 4'h0);

    // counter: loads one cycle after start, refresh, wd reset with keep bit or gp start/overflow
    wire load_evt = wd_start_new || refresh_hit || gp_start_new || gp_ovf
        || (wd_ovf && keep_r);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= COUNT_RST;
            load_pend_r <= 1'b0;
        end else begin
            load_pend_r <= load_evt;
            if (wd_ovf)
                cnt_r <= COUNT_RST;
            else if (load_pend_r)
                cnt_r <= {reload_r, 8'h00};
            else if (cnt_tick)
                cnt_r <= cnt_r + 16'h0001;
        end
    end

    // overflow flag and interrupt source: set beats clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_flag_r <= 1'b0;
            irq_src_r <= 1'b0;
        end else begin
            if (gp_ovf)
                ovf_flag_r <= 1'b1;
            else if (gp_start_new)
                ovf_flag_r <= 1'b0;
            else if (wr_status && !wr_data[STAT_OVF])
                ovf_flag_r <= 1'b0;
            if (gp_ovf)
                irq_src_r <= 1'b1;
            else if (irq_src_clear || (wr_status && !wr_data[STAT_IRQ_SRC]))
                irq_src_r <= 1'b0;
        end
    end
    assign gp_timer_irq_source = irq_src_r;
    assign gp_timer_irq = irq_src_r && gp_timer_irq_enable;

    // read mux; counter registers are read only
    wire [31:0] ctrl_word = {26'h0, wd_rst_flag_r, keep_r, gp_run_r, tmr_mode_r,
        prescale_r, start_r};
    logic [31:0] rd_word;
    logic rd_known;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_known = 1'b1;
        case (s_araddr)
            ADDR_RELOAD: rd_word = {24'h00_0000, reload_r};
            ADDR_REFRESH: rd_word = {31'h0000_0000, refresh_r};
            ADDR_CTRL: rd_word = ctrl_word;
            ADDR_CNT_LOW: rd_word = {24'h00_0000, cnt_r[7:0]};
            ADDR_CNT_HIGH: rd_word = {24'h00_0000, cnt_r[15:8]};
            ADDR_STATUS: rd_word = {30'h0000_0000, irq_src_r, ovf_flag_r};
            default: rd_known = 1'b0;
        endcase
    end
    assign s_arready = !rvalid_r;
    assign s_rvalid = rvalid_r;
    assign s_rdata = rdata_r;
    assign s_rresp = rresp_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_got_r <= 1'b1;
                    aw_addr_r <= s_awaddr;
                end
                if (w_take) begin
                    w_got_r <= 1'b1;
                    w_data_r <= s_wdata;
                    w_strb_r <= s_wstrb;
                end
                if (bvalid_r && s_bready)
                    bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_r && s_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // assertions
    sequence wd_wrap_s;
        wd_ovf;
    endsequence
    sequence rst_pulse_s;
        wd_reset_out [*8];
    endsequence

    wd_reset_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
        wd_wrap_s |=> rst_pulse_s)
        else $error("watchdog wrap did not raise reset");
    start_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wd_start_new && !wd_ovf) |=> ##1 (cnt_r == {$past(reload_r), 8'h00}))
        else $error("start did not load counter");
    wd_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
        start_r |=> start_r)
        else $error("watchdog stopped by software");
    mode_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        start_r |=> !tmr_mode_r)
        else $error("timer mode set while watchdog runs");
    refresh_life_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(refresh_r) |-> ##[1:40] !refresh_r)
        else $error("refresh bit did not self clear");
    gp_no_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        gp_ovf |=> (ovf_flag_r && irq_src_r && !wd_reset_out))
        else $error("timer overflow handled wrongly");
    idle_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wd_running && pwr.idle_mode && !load_pend_r && !wd_ovf) |=> $stable(cnt_r))
        else $error("watchdog counted in idle");
    peripheral_save_bit_freeze_a: assert property (@(posedge clk) disable iff (!rst_n)
        (gp_running && pwr.peripheral_save_bit_save && !load_pend_r) |=> $stable(cnt_r))
        else $error("timer counted under peripheral save");
    count_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cnt_tick && !load_pend_r && !wd_ovf) |=> (cnt_r == $past(cnt_r) + 16'h0001))
        else $error("counter did not step up");
    keep_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wd_ovf && !keep_r && !wr_reload) |=> (reload_r == RELOAD_RST && !prescale_r))
        else $error("reload not cleared on watchdog reset");

    mtick_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
        mtick |=> (!mtick) [*8])
        else $error("machine tick came early");

    wrap_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        wrap |=> !wrap)
        else $error("counter wrapped twice in a row");

    gp_reload_a: assert property (@(posedge clk) disable iff (!rst_n)
        gp_ovf |=> ##1 (cnt_r == {$past(reload_r), 8'h00}))
        else $error("timer did not reload after overflow");

    refresh_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        (refresh_hit ##1 !wd_ovf) |=> (cnt_r == {$past(reload_r), 8'h00}))
        else $error("refresh did not reload counter");

    gp_start_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        gp_start_new |=> !ovf_flag_r)
        else $error("timer start left overflow flag set");

    power_halt_a: assert property (@(posedge clk) disable iff (!rst_n)
        (pwr.power_down && !load_pend_r) |=> $stable(cnt_r))
        else $error("counter moved in power down");

    gp_mode_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
        (gp_running && !(wr_ctrl && !new_gp)) |=> tmr_mode_r)
        else $error("timer mode left while timer runs");

    start_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(start_r) |-> !tmr_mode_r)
        else $error("watchdog started in timer mode");

    cnt_readonly_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_fire && (wr_addr == ADDR_CNT_LOW || wr_addr == ADDR_CNT_HIGH)
            && !cnt_tick && !load_pend_r) |=> $stable(cnt_r))
        else $error("counter changed by a bus write");

    reload_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        (!wr_reload && !wd_ovf) |=> $stable(reload_r))
        else $error("reload changed without a write");

    wd_reset_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        wd_ovf |=> (start_r && wd_rst_flag_r && cnt_r == COUNT_RST))
        else $error("watchdog reset lost start or source flag");

    keep_retain_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wd_ovf && keep_r && !wr_reload) |=> (reload_r == $past(reload_r)
            && prescale_r == $past(prescale_r)))
        else $error("keep bit did not retain configuration");

    gp_flag_only_a: assert property (@(posedge clk) disable iff (!rst_n)
        gp_ovf |=> $stable(wd_rst_flag_r))
        else $error("timer overflow touched reset source flag");
endmodule

// ===== testbench.sv
// self-checking bench for the watchdog block, driven over its AXI4-Lite slave
// assumes wdog_pkg and wdog are compiled first; the bench drives every port itself
`timescale 1ns/1ps
module testbench import wdog_pkg::*;;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    power_t pwr = '0;
    logic irq_src_clear = 1'b0;
    logic gp_timer_irq_enable = 1'b0;
    logic [7:0] s_awaddr = 8'h00;
    logic [7:0] s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0000_0000;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 1'b0;
    logic s_wvalid = 1'b0;
    logic s_bready = 1'b0;
    logic s_arvalid = 1'b0;
    logic s_rready = 1'b0;
    logic wd_reset_out, gp_timer_irq_source, gp_timer_irq;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    logic [7:0] addrs [6] = '{ADDR_RELOAD, ADDR_REFRESH, ADDR_CTRL, ADDR_CNT_LOW,
        ADDR_CNT_HIGH, ADDR_STATUS};
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;

    wdog wdog_i (.clk, .rst_n, .pwr, .wd_reset_out, .gp_timer_irq_source, .irq_src_clear,
        .gp_timer_irq_enable, .gp_timer_irq, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
        .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);

    always #5 clk = ~clk;

    task automatic tally_and_finish();
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // the whole run needs about 31000 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            tally_and_finish();
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL at %0t: response %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
        s_awaddr <= a;
        s_wdata <= {24'h00_0000, d};
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        // only s_bvalid or the bench timeout ends this wait
        do begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        chk_resp(s_bresp, er);
        s_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [7:0] d);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        chk_resp(s_rresp, er);
        d = s_rdata[7:0];
        s_rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, RESP_OKAY, d);
        chk_val(d, e);
    endtask

    // counter low byte must advance by lo..hi steps over w cycles
    task automatic rate(input int w, input int lo, input int hi);
        logic [7:0] a;
        logic [7:0] b;
        rd(ADDR_CNT_LOW, RESP_OKAY, a);
        repeat (w) @(posedge clk);
        rd(ADDR_CNT_LOW, RESP_OKAY, b);
        chk_val(8'(b - a) >= lo && 8'(b - a) <= hi, 1'b1);
    endtask

    // reload 0xFF at divide-by-2: 256 steps of 24 clocks to the wrap
    task automatic wait_event(input bit tmr);
        int n;
        int len;
        bit seen;
        n = 0;
        len = 0;
        seen = 1'b0;
        while (!(tmr ? gp_timer_irq_source : wd_reset_out) && n < 8000) begin
            @(posedge clk);
            n++;
            seen |= wd_reset_out;
        end
        while (wd_reset_out && len < 40) begin
            @(posedge clk);
            len++;
        end
        chk_val(n >= 6100 && n <= 6180, 1'b1);
        chk_val(tmr ? seen : len, tmr ? 0 : WD_RST_LEN);
    endtask

    initial begin
        logic [7:0] d;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (addrs[i]) rdc(addrs[i], 8'h00);
        rd(8'h18, RESP_SLVERR, d);
        wr(8'h18, 8'hFF, RESP_SLVERR);
        wr(ADDR_CNT_HIGH, 8'h55);
        wr(ADDR_CNT_LOW, 8'h55);
        rdc(ADDR_CNT_HIGH, 8'h00);
        rdc(ADDR_CNT_LOW, 8'h00);
        wr(ADDR_RELOAD, 8'h80);
        rdc(ADDR_CNT_HIGH, 8'h00);
        wr(ADDR_CTRL, 8'h01);
        rdc(ADDR_CNT_HIGH, 8'h80);
        rd(ADDR_CNT_LOW, RESP_OKAY, d);
        chk_val(d < 8'h02, 1'b1);
        wr(ADDR_CTRL, 8'h04);
        rdc(ADDR_CTRL, 8'h01);
        pwr <= power_t'(3'b100);
        rate(100, 0, 0);
        pwr <= power_t'(3'b001);
        rate(100, 4, 5);
        pwr <= '0;
        // refresh broken by a write in between must not reload
        wr(ADDR_REFRESH, 8'h01);
        rdc(ADDR_REFRESH, 8'h01);
        wr(ADDR_RELOAD, 8'hFF);
        wr(ADDR_CTRL, 8'h01);
        rdc(ADDR_CNT_HIGH, 8'h80);
        repeat (40) @(posedge clk);
        rdc(ADDR_REFRESH, 8'h00);
        wr(ADDR_REFRESH, 8'h01);
        wr(ADDR_CTRL, 8'h01);
        rdc(ADDR_CNT_HIGH, 8'hFF);
        wait_event(1'b0);
        rdc(ADDR_CTRL, 8'h21);
        rdc(ADDR_RELOAD, 8'h00);
        rdc(ADDR_CNT_HIGH, 8'h00);
        // second overflow with the keep bit set
        wr(ADDR_RELOAD, 8'hFF);
        wr(ADDR_REFRESH, 8'h01);
        wr(ADDR_CTRL, 8'h11);
        wait_event(1'b0);
        rdc(ADDR_CTRL, 8'h31);
        rdc(ADDR_RELOAD, 8'hFF);
        rdc(ADDR_CNT_HIGH, 8'hFF);
        pwr <= power_t'(3'b010);
        rate(100, 0, 0);
        pwr <= '0;
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (addrs[i]) rdc(addrs[i], 8'h00);
        // timer mode
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_CTRL, 8'h05);
        rdc(ADDR_CTRL, 8'h04);
        wr(ADDR_RELOAD, 8'hFF);
        // a write without the low byte lane must leave the reload value alone
        s_wstrb <= 4'hE;
        wr(ADDR_RELOAD, 8'h11);
        s_wstrb <= 4'hF;
        rdc(ADDR_RELOAD, 8'hFF);
        wr(ADDR_CTRL, 8'h0E);
        rdc(ADDR_CNT_HIGH, 8'hFF);
        rate(4608, 3, 4);
        wr(ADDR_CTRL, 8'h06);
        rate(100, 0, 0);
        wr(ADDR_CTRL, 8'h0C);
        gp_timer_irq_enable <= 1'b1;
        wait_event(1'b1);
        rdc(ADDR_STATUS, 8'h03);
        chk_val(gp_timer_irq, 1'b1);
        rdc(ADDR_CTRL, 8'h0C);
        rdc(ADDR_CNT_HIGH, 8'hFF);
        wr(ADDR_CTRL, 8'h08);
        rdc(ADDR_CTRL, 8'h0C);
        gp_timer_irq_enable <= 1'b0;
        pwr <= power_t'(3'b001);
        rate(100, 0, 0);
        chk_val(gp_timer_irq, 1'b0);
        pwr <= power_t'(3'b100);
        rate(100, 4, 5);
        pwr <= '0;
        wr(ADDR_CTRL, 8'h04);
        wr(ADDR_CTRL, 8'h0C);
        rdc(ADDR_STATUS, 8'h02);
        irq_src_clear <= 1'b1;
        @(posedge clk);
        irq_src_clear <= 1'b0;
        rdc(ADDR_STATUS, 8'h00);
        chk_val(gp_timer_irq_source, 1'b0);
        // let the running timer overflow once more, then clear only the flag
        while (!gp_timer_irq_source) @(posedge clk);
        wr(ADDR_STATUS, 8'h02);
        rdc(ADDR_STATUS, 8'h02);
        wr(ADDR_CTRL, 8'h00);
        rdc(ADDR_CTRL, 8'h00);
        rate(100, 0, 0);
        tally_and_finish();
    end
endmodule
